/* File: dv/test_temp_fault_response_ctrl.sv */
// Self-checking bench for the temperature fault response block
`timescale 1ns/1ps
`default_nettype none
module test_temp_fault_response_ctrl;
   import tfr_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] run_pin = '0;
   logic [1:0] op_on = '0;
   logic die_ot = 1'b0;
   logic adc = 1'b0;
   logic [1:0] ext_ot = '0;
   logic [1:0] ext_ut = '0;
   logic [7:0] rd_data;
   logic [1:0] oe;
   logic alert;
   logic clear_faults;
   tfr_status_s status;
   tfr_cmd_s cmd;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   int k;
   integer seed = 32'h55f7;
   logic [7:0] v;
   logic pg, p, bad;
   logic [7:0] codes [3] = '{TFR_CMD_EXT_OT, TFR_CMD_EXT_UT, TFR_CMD_DIE_OT};
   logic [7:0] mdl [3][2] = '{'{2{TFR_EXT_RESET}}, '{2{TFR_EXT_RESET}}, '{2{TFR_DIE_RESET}}};
   // 125 MHz clock and a hang ceiling far above the run length
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   tfr_host tfr_host_inst (.clk(clk), .cmd(cmd), .clear_faults(clear_faults));
   tfr_temp_fault_resp tfr_temp_fault_resp_inst (.clk(clk), .nrst(nrst), .cmd(cmd), .clear_faults(clear_faults),
      .rd_data(rd_data), .output_run_pin(run_pin), .operation_on(op_on), .retry_delay_cycles(24'h000014),
      .output_enable(oe), .die_ot_fault(die_ot), .adc_sample(adc), .ext_ot_fault(ext_ot), .ext_ut_fault(ext_ut),
      .status(status), .alert(alert));
   // Value a write leaves behind: refused bytes keep the old one
   function automatic logic [7:0] stored(input logic [7:0] code, input logic [7:0] old, input logic [7:0] nw);
      if (code == TFR_CMD_DIE_OT)
         return (nw[7] && nw[5:3] == 3'h0) ? nw : old;
      return nw[6] ? old : nw;
   endfunction : stored
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic rd(input logic pg, input logic [7:0] code, input logic [7:0] exp);
      tfr_host_inst.xfer(1'b0, pg, code, 8'h00);
      step(1);
      chk("rd_data", 9'(exp), 9'(rd_data));
   endtask : rd
   // One converter sample carrying the given fault lines
   task automatic ext_hit(input logic [1:0] ot, input logic [1:0] ut);
      adc = 1'b1;
      ext_ot = ot;
      ext_ut = ut;
      step(1);
      adc = 1'b0;
      ext_ot = 2'b00;
      ext_ut = 2'b00;
   endtask : ext_hit
   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      step(10);
      nrst = 1'b1;
      run_pin = 2'b11;
      op_on = 2'b11;
      step(6);
      chk("oe", 9'h003, 9'(oe));
      rd(1'b0, 8'h33, TFR_RD_UNMAPPED);
      rd(1'b0, TFR_CMD_EXT_OT, TFR_EXT_RESET);
      rd(1'b1, TFR_CMD_EXT_UT, TFR_EXT_RESET);
      rd(1'b0, TFR_CMD_DIE_OT, TFR_DIE_RESET);
      for (int i = 0; i < 30; i++) begin
         v = 8'($random(seed));
         k = i % 3;
         pg = i[2];
         p = (k == 2) ? 1'b0 : pg;
         bad = stored(codes[k], ~v, v) !== v;
         tfr_host_inst.xfer(1'b1, pg, codes[k], v);
         step(1);
         chk("status", {2'h0, bad, 6'h00}, status);
         mdl[k][p] = stored(codes[k], mdl[k][p], v);
         rd(pg, codes[k], mdl[k][p]);
         tfr_host_inst.clear();
      end
      // Die code 11: off only while hot, flags stay
      tfr_host_inst.xfer(1'b1, 1'b0, TFR_CMD_DIE_OT, 8'hC7);
      die_ot = 1'b1;
      step(3);
      chk("oe", 9'h000, 9'(oe));
      chk("status", 9'h180, status);
      chk("alert", 9'h001, 9'(alert));
      die_ot = 1'b0;
      step(6);
      chk("oe", 9'h003, 9'(oe));
      chk("status", 9'h180, status);
      tfr_host_inst.clear();
      // Die code 10 with no retry: latched until cleared
      tfr_host_inst.xfer(1'b1, 1'b1, TFR_CMD_DIE_OT, 8'h80);
      die_ot = 1'b1;
      step(1);
      die_ot = 1'b0;
      step(30);
      chk("oe", 9'h000, 9'(oe));
      tfr_host_inst.clear();
      step(4);
      chk("oe", 9'h003, 9'(oe));
      // Ext code 00: flag only, output keeps running
      tfr_host_inst.xfer(1'b1, 1'b0, TFR_CMD_EXT_OT, 8'h00);
      ext_hit(2'b01, 2'b00);
      step(2);
      chk("status", 9'h014, status);
      chk("oe", 9'h003, 9'(oe));
      tfr_host_inst.clear();
      // Ext undertemp, retry 000 on page 1, freed by a run pin cycle
      tfr_host_inst.xfer(1'b1, 1'b1, TFR_CMD_EXT_UT, 8'h80);
      ext_hit(2'b00, 2'b10);
      step(40);
      chk("oe", 9'h001, 9'(oe));
      chk("status", 9'h022, status);
      run_pin = 2'b01;
      step(4);
      run_pin = 2'b11;
      step(6);
      chk("oe", 9'h003, 9'(oe));
      chk("status", 9'h000, status);
      // Ext overtemp, retry 111: restart after the retry delay
      tfr_host_inst.xfer(1'b1, 1'b0, TFR_CMD_EXT_OT, 8'hB8);
      ext_hit(2'b01, 2'b00);
      step(2);
      chk("oe", 9'h002, 9'(oe));
      step(15);
      chk("oe", 9'h002, 9'(oe));
      step(10);
      chk("oe", 9'h003, 9'(oe));
      // Commanded off mid-wait: restarts stop, the on-cycle frees at once
      ext_hit(2'b01, 2'b00);
      op_on = 2'b10;
      step(3);
      chk("oe", 9'h002, 9'(oe));
      op_on = 2'b11;
      step(3);
      chk("oe", 9'h003, 9'(oe));
      chk("status", 9'h000, status);
      end_sim();
   end
endmodule : test_temp_fault_response_ctrl
`default_nettype wire

/* File: dv/tfr_host.sv */
// Host model issuing command and clear-faults pulses
`timescale 1ns/1ps
`default_nettype none
module tfr_host (
   // Clock
   input wire logic clk,
   // Command side
   output var tfr_pkg::tfr_cmd_s cmd,
   output logic clear_faults
);
   import tfr_pkg::*;
   initial begin
      cmd = '0;
      clear_faults = 1'b0;
   end
   // One-cycle strobe, launched just after an edge so the design never races it
   task automatic xfer(input logic wr, input logic pg, input logic [7:0] code, input logic [7:0] d);
      @(posedge clk);
      #1;
      cmd = '{wr: wr, rd: !wr, page: pg, code: code, wdata: d};
      @(posedge clk);
      #1;
      cmd = '0;
   endtask : xfer
   task automatic clear();
      @(posedge clk);
      #1;
      clear_faults = 1'b1;
      @(posedge clk);
      #1;
      clear_faults = 1'b0;
   endtask : clear
endmodule : tfr_host
`default_nettype wire

/* File: dv/tfr_temp_fault_resp_properties.sv */
// Port assertions for the temperature fault response block
`timescale 1ns/1ps
`default_nettype none
module tfr_temp_fault_resp_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Commands and fault inputs
   input wire tfr_pkg::tfr_cmd_s cmd,
   input wire logic clear_faults,
   input wire logic die_ot_fault,
   input wire logic adc_sample,
   input wire logic [tfr_pkg::TFR_PAGES-1:0] ext_ot_fault,
   input wire logic [tfr_pkg::TFR_PAGES-1:0] ext_ut_fault,
   // Results
   input wire logic [tfr_pkg::TFR_PAGES-1:0] output_enable,
   input wire tfr_pkg::tfr_status_s status,
   input wire logic alert
);
   import tfr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Refused writes: odd response code on ext, low code or retry on die
   sequence s_bad_ext;
      cmd.wr && (cmd.code == TFR_CMD_EXT_OT || cmd.code == TFR_CMD_EXT_UT) && cmd.wdata[6];
   endsequence
   sequence s_bad_die;
      cmd.wr && cmd.code == TFR_CMD_DIE_OT && (!cmd.wdata[7] || cmd.wdata[5:3] != 3'h0);
   endsequence
   // Flag first, alert one cycle behind it
   sequence s_cml_alert;
      status.cml ##1 alert;
   endsequence
   a_bad_ext_cml: assert property (s_bad_ext |=> s_cml_alert)
      else $error("Refused ext write gave no CML");
   a_bad_die_cml: assert property (s_bad_die |=> s_cml_alert)
      else $error("Refused die write gave no CML");
   a_cml_sticky: assert property (status.cml && !clear_faults |=> status.cml)
      else $error("CML dropped without clear");
   a_die_flags: assert property (die_ot_fault |=> status.mfr_die_ot && status.mfr_summary ##1 alert)
      else $error("Die fault flags or alert missing");
   a_die_shut: assert property (die_ot_fault ##1 die_ot_fault |=> output_enable == '0)
      else $error("Output still on during die fault");
   a_ext_ot_flag: assert property (adc_sample && ext_ot_fault != '0 |=>
      (status.temp_ot & $past(ext_ot_fault)) == $past(ext_ot_fault) && status.temp_summary != '0)
      else $error("Ext overtemp flags missing");
   a_ext_ut_flag: assert property (adc_sample && ext_ut_fault != '0 |=>
      (status.temp_ut & $past(ext_ut_fault)) == $past(ext_ut_fault) && status.temp_summary != '0)
      else $error("Ext undertemp flags missing");
   a_alert_raise: assert property (status.mfr_summary || status.temp_summary != '0 |=> alert)
      else $error("Alert not raised by status");
endmodule : tfr_temp_fault_resp_properties
bind tfr_temp_fault_resp tfr_temp_fault_resp_properties tfr_props_inst (.clk(clk), .nrst(nrst), .cmd(cmd),
   .clear_faults(clear_faults), .die_ot_fault(die_ot_fault), .adc_sample(adc_sample), .ext_ot_fault(ext_ot_fault),
   .ext_ut_fault(ext_ut_fault), .output_enable(output_enable), .status(status), .alert(alert));
`default_nettype wire

/* File: verilog/tfr_pkg.sv */
// Package with constants and carriers for the temperature fault response block
// Overview of operation
// - Die overtemp sets summary, mfr bit, alert
// - Die response codes 00, 01 raise CML
// - Die code 10 disables output, obeys retry
// - Die code 11 disables only while fault
// - Fault bits sticky until clear, cycle, reset; CML clears only on clear or reset
// - Die retry 000 means no self restart
// - Die retry codes 001-111 raise CML
// - Die delay-time bits are ignored
// - External overtemp applies response, sets bits, alerts
// - External undertemp applies response, sets bits, alerts
// - External response starts within 90ms
// - Per-page external response bytes reset 0xB8
// - External code 00 continues; 01, 11 CML
// - External retry 000-110 means latched off
// - External retry 111 restarts after retry delay
// - External delay-time bits are ignored
`default_nettype none
package tfr_pkg;
   // Geometry
   localparam int TFR_PAGES = 2;
   localparam int TFR_DLY_W = 24;
   // Command codes of the response bytes
   localparam logic [7:0] TFR_CMD_EXT_OT = 8'h50;
   localparam logic [7:0] TFR_CMD_EXT_UT = 8'h54;
   localparam logic [7:0] TFR_CMD_DIE_OT = 8'hD6;
   // Reset values
   localparam logic [7:0] TFR_EXT_RESET = 8'hB8;
   localparam logic [7:0] TFR_DIE_RESET = 8'hC0;
   localparam logic [7:0] TFR_RD_UNMAPPED = 8'h00;
   // Response field codes, bits 7:6
   localparam logic [1:0] TFR_RSP_CONT = 2'h0;
   localparam logic [1:0] TFR_RSP_BAD01 = 2'h1;
   localparam logic [1:0] TFR_RSP_SHUT = 2'h2;
   localparam logic [1:0] TFR_RSP_WHILE = 2'h3;
   // Retry field codes, bits 5:3
   localparam logic [2:0] TFR_RETRY_NONE = 3'h0;
   localparam logic [2:0] TFR_RETRY_CONT = 3'h7;
   // Response detection latency bound
   localparam int TFR_RESP_MAX_MS = 90;
   localparam int TFR_CLK_KHZ = 125000;
   localparam longint TFR_RESP_MAX_CYC = longint'(TFR_RESP_MAX_MS) * longint'(TFR_CLK_KHZ);

   // Response byte layout; delay-time bits are kept and read back but never acted on
   typedef struct packed {
      logic [1:0] rsp;
      logic [2:0] retry;
      logic [2:0] delay;
   } tfr_resp_s;

   // Command port from the serial front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic page;
      logic [7:0] code;
      logic [7:0] wdata;
   } tfr_cmd_s;

   // Status bits shown to the status registers
   typedef struct packed {
      logic mfr_summary;
      logic mfr_die_ot;
      logic cml;
      logic [TFR_PAGES-1:0] temp_summary;
      logic [TFR_PAGES-1:0] temp_ot;
      logic [TFR_PAGES-1:0] temp_ut;
   } tfr_status_s;

   // Per-page shutdown state
   typedef enum logic [1:0] {
      TFR_RUN = 2'b00,
      TFR_LATCHED = 2'b01,
      TFR_RETRY_WAIT = 2'b10
   } tfr_state_e;
endpackage : tfr_pkg
`default_nettype wire

/* File: verilog/tfr_temp_fault_resp.sv */
// Temperature fault response registers and shutdown control
`timescale 1ns/1ps
`default_nettype none
module tfr_temp_fault_resp (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Decoded command access
   input wire tfr_pkg::tfr_cmd_s cmd,
   input wire logic clear_faults,
   output logic [7:0] rd_data,
   // Output control
   input wire logic [tfr_pkg::TFR_PAGES-1:0] output_run_pin,
   input wire logic [tfr_pkg::TFR_PAGES-1:0] operation_on,
   input wire logic [tfr_pkg::TFR_DLY_W-1:0] retry_delay_cycles,
   output logic [tfr_pkg::TFR_PAGES-1:0] output_enable,
   // Fault conditions; external ones sampled per converter result, die fault taken as a level
   input wire logic die_ot_fault,
   input wire logic adc_sample,
   input wire logic [tfr_pkg::TFR_PAGES-1:0] ext_ot_fault,
   input wire logic [tfr_pkg::TFR_PAGES-1:0] ext_ut_fault,
   // Status and alert
   output var tfr_pkg::tfr_status_s status,
   output logic alert
);
   import tfr_pkg::*;

   localparam int P = TFR_PAGES;

   // External response write is legal unless code 01 or 11
   function automatic logic ext_ok(input tfr_resp_s r);
      ext_ok = (r.rsp != TFR_RSP_BAD01) && (r.rsp != TFR_RSP_WHILE);
   endfunction : ext_ok

   // Die response write needs code 10/11 and retry 000; delay bits are don't-care
   // Any delay value is accepted, so a write never fails on those bits
   function automatic logic die_ok(input tfr_resp_s r);
      die_ok = ((r.rsp == TFR_RSP_SHUT) || (r.rsp == TFR_RSP_WHILE)) && (r.retry == TFR_RETRY_NONE);
   endfunction : die_ok

   // Run pin synchroniser, two flops before any use
   // Resets low, so a pin already high at release counts as an on-cycle
   logic [P-1:0] run_s1_q, run_s2_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_s1_q <= '0;
         run_s2_q <= '0;
      end else begin
         run_s1_q <= output_run_pin;
         run_s2_q <= run_s1_q;
      end
   end

   // Commanded-on state and its rising edge
   logic [P-1:0] cmd_on, cmd_on_q, cmd_on_d, on_rise;
   always_comb begin
      cmd_on = run_s2_q & operation_on;
      cmd_on_d = cmd_on;
      on_rise = cmd_on & ~cmd_on_q;
   end

   // Response byte storage
   tfr_resp_s ext_ot_q [P], ext_ot_d [P];
   tfr_resp_s ext_ut_q [P], ext_ut_d [P];
   tfr_resp_s die_q, die_d;
   logic cml_set;
   logic [7:0] rd_data_q, rd_data_d;

   // Write decode; an illegal byte is dropped and flags CML instead
   always_comb begin
      cml_set = 1'b0;
      die_d = die_q;
      for (int p = 0; p < P; p++) begin
         ext_ot_d[p] = ext_ot_q[p];
         ext_ut_d[p] = ext_ut_q[p];
      end
      if (cmd.wr) begin
         case (cmd.code)
            TFR_CMD_EXT_OT: begin
               if (ext_ok(tfr_resp_s'(cmd.wdata))) begin
                  ext_ot_d[cmd.page] = tfr_resp_s'(cmd.wdata);
               end else begin
                  cml_set = 1'b1;
               end
            end
            TFR_CMD_EXT_UT: begin
               if (ext_ok(tfr_resp_s'(cmd.wdata))) begin
                  ext_ut_d[cmd.page] = tfr_resp_s'(cmd.wdata);
               end else begin
                  cml_set = 1'b1;
               end
            end
            TFR_CMD_DIE_OT: begin
               if (die_ok(tfr_resp_s'(cmd.wdata))) begin
                  die_d = tfr_resp_s'(cmd.wdata);
               end else begin
                  cml_set = 1'b1;
               end
            end
            default: begin
               cml_set = 1'b0;
            end
         endcase
      end
   end

   // Read mux, registered so data comes from flops
   // Holding the last byte keeps rd_data steady between reads
   always_comb begin
      rd_data_d = rd_data_q;
      if (cmd.rd) begin
         case (cmd.code)
            TFR_CMD_EXT_OT: rd_data_d = ext_ot_q[cmd.page];
            TFR_CMD_EXT_UT: rd_data_d = ext_ut_q[cmd.page];
            TFR_CMD_DIE_OT: rd_data_d = die_q;
            default: rd_data_d = TFR_RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int p = 0; p < P; p++) begin
            ext_ot_q[p] <= TFR_EXT_RESET;
            ext_ut_q[p] <= TFR_EXT_RESET;
         end
         die_q <= TFR_DIE_RESET;
         rd_data_q <= TFR_RD_UNMAPPED;
         cmd_on_q <= '0;
      end else begin
         ext_ot_q <= ext_ot_d;
         ext_ut_q <= ext_ut_d;
         die_q <= die_d;
         rd_data_q <= rd_data_d;
         cmd_on_q <= cmd_on_d;
      end
   end

   // Fault events: die fault is a level, external ones only on converter samples
   // Die fault comes from logic on this clock, so it is not synchronised
   logic die_evt;
   logic [P-1:0] ot_evt, ut_evt;
   always_comb begin
      die_evt = die_ot_fault;
      ot_evt = ext_ot_fault & {P{adc_sample}};
      ut_evt = ext_ut_fault & {P{adc_sample}};
   end

   // Sticky status; a new event wins over a clear in the same cycle
   // Die bits belong to no page, so either page's on-cycle clears them
   tfr_status_s st_q, st_d;
   logic any_rise;
   always_comb begin
      any_rise = |on_rise;
      st_d = st_q;
      if (clear_faults || any_rise) begin
         st_d.mfr_summary = 1'b0;
         st_d.mfr_die_ot = 1'b0;
      end
      if (clear_faults) begin
         st_d.cml = 1'b0;
      end
      for (int p = 0; p < P; p++) begin
         if (clear_faults || on_rise[p]) begin
            st_d.temp_summary[p] = 1'b0;
            st_d.temp_ot[p] = 1'b0;
            st_d.temp_ut[p] = 1'b0;
         end
         if (ot_evt[p]) begin
            st_d.temp_summary[p] = 1'b1;
            st_d.temp_ot[p] = 1'b1;
         end
         if (ut_evt[p]) begin
            st_d.temp_summary[p] = 1'b1;
            st_d.temp_ut[p] = 1'b1;
         end
      end
      if (die_evt) begin
         st_d.mfr_summary = 1'b1;
         st_d.mfr_die_ot = 1'b1;
      end
      if (cml_set) begin
         st_d.cml = 1'b1;
      end
   end

   // Die latch: code 10 with retry 000 stays off until a clear or on-cycle
   logic die_off_q, die_off_d, die_hold;
   always_comb begin
      die_off_d = die_off_q;
      if (clear_faults || any_rise) begin
         die_off_d = 1'b0;
      end
      if (die_evt && die_q.rsp == TFR_RSP_SHUT) begin
         die_off_d = 1'b1;
      end
      // Only the response field is read; delay bits are stored but unused
      // Code 11 follows the live fault, no latch
      die_hold = die_ot_fault && (die_q.rsp == TFR_RSP_WHILE);
   end

   // Per-page external shutdown machine; delay-time bits are never consulted
   // A page that is off when the fault hits stays in RUN; nothing to shut down
   // The wait counter restarts from zero on each shutdown so spacing is exact
   // Limitation: retry_delay_cycles is read live, so a change mid-wait moves the end
   tfr_state_e ext_st_q [P], ext_st_d [P];
   logic [TFR_DLY_W-1:0] wait_q [P], wait_d [P];
   tfr_resp_s act;
   logic hit;
   always_comb begin
      act = '0;
      hit = 1'b0;
      for (int p = 0; p < P; p++) begin
         ext_st_d[p] = ext_st_q[p];
         wait_d[p] = wait_q[p];
         // Overtemp byte takes precedence when both fire together with shutdown code 10
         hit = 1'b0;
         act = ext_ot_q[p];
         if (ot_evt[p] && ext_ot_q[p].rsp == TFR_RSP_SHUT) begin
            hit = 1'b1;
         end else if (ut_evt[p] && ext_ut_q[p].rsp == TFR_RSP_SHUT) begin
            hit = 1'b1;
            act = ext_ut_q[p];
         end
         case (ext_st_q[p])
            TFR_RUN: begin
               if (hit && cmd_on[p]) begin
                  wait_d[p] = '0;
                  if (act.retry == TFR_RETRY_CONT) begin
                     ext_st_d[p] = TFR_RETRY_WAIT;
                  end else begin
                     ext_st_d[p] = TFR_LATCHED;
                  end
               end
            end
            TFR_LATCHED: begin
               // Only a clear or an off/on cycle lets it go
               if (clear_faults || on_rise[p]) begin
                  ext_st_d[p] = TFR_RUN;
               end
            end
            TFR_RETRY_WAIT: begin
               if (!cmd_on[p] || die_off_q) begin
                  ext_st_d[p] = TFR_LATCHED;
               end else if (wait_q[p] >= retry_delay_cycles) begin
                  ext_st_d[p] = TFR_RUN;
               end else begin
                  wait_d[p] = wait_q[p] + 1'b1;
               end
            end
            default: begin
               ext_st_d[p] = TFR_RUN;
            end
         endcase
      end
   end

   // Output enable and alert, both registered
   // Code 11 hold uses the live fault, so the output returns one cycle after it clears
   logic [P-1:0] out_en_q, out_en_d;
   logic alert_q, alert_d;
   always_comb begin
      for (int p = 0; p < P; p++) begin
         out_en_d[p] = cmd_on[p] && (ext_st_q[p] == TFR_RUN) && !die_off_q && !die_hold;
      end
      // Any sticky fault bit keeps the alert asserted
      alert_d = st_q.mfr_summary | st_q.cml | (|st_q.temp_summary);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
         die_off_q <= 1'b0;
         for (int p = 0; p < P; p++) begin
            ext_st_q[p] <= TFR_RUN;
            wait_q[p] <= '0;
         end
         out_en_q <= '0;
         alert_q <= 1'b0;
      end else begin
         st_q <= st_d;
         die_off_q <= die_off_d;
         ext_st_q <= ext_st_d;
         wait_q <= wait_d;
         out_en_q <= out_en_d;
         alert_q <= alert_d;
      end
   end

   // Outputs
   assign rd_data = rd_data_q;
   assign output_enable = out_en_q;
   assign status = st_q;
   assign alert = alert_q;
endmodule : tfr_temp_fault_resp
`default_nettype wire
